// ===== cad_pkg.sv
// Shared types and constants for the CPU arithmetic/logic/bit datapath.
// Assumes one clock domain and a synchronous active-high reset.
package cad_pkg;

    // General register file shape
    localparam int NUM_GPR = 8;
    localparam int GPR_W = 32;
    localparam logic [31:0] GPR_RESET = 32'h0000_0000;

    // Condition code bit positions and value after reset
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam logic [7:0] CC_RESET = 8'h00;

    // Divider width: divisor bits of the wide form
    localparam int DIV_W = 16;

    // Operand size
    typedef enum logic [1:0] {
        SZ_B = 2'b00,
        SZ_W = 2'b01,
        SZ_L = 2'b10
    } cad_size_t;

    // Decoded operation
    typedef enum logic [4:0] {
        OP_DIVU, OP_DIVS, OP_CMP, OP_NEG, OP_EXTS, OP_EXTU,
        OP_AND, OP_OR, OP_XOR, OP_NOT,
        OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT,
        OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
        OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
        OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY,
        OP_SINGLE_BIT_SET, OP_SINGLE_BIT_CLEAR, OP_SINGLE_BIT_INVERT,
        OP_SINGLE_BIT_TEST, OP_CARRY_AND_BIT, OP_CARRY_AND_INVERTED_BIT
    } cad_op_t;

    // Controller states, Gray along idle-exec-divide
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DIV = 2'b11
    } cad_state_t;

    // One decoded instruction
    typedef struct packed {
        cad_op_t op;
        cad_size_t size;
        logic [3:0] dst;
        logic [3:0] src;
        logic use_imm;
        logic use_mem;
        logic [31:0] imm;
    } cad_req_t;

    // Byte memory write-back
    typedef struct packed {
        logic we;
        logic [7:0] data;
    } cad_mem_t;

endpackage : cad_pkg

// ===== cad_divider.sv
// Restoring unsigned divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse given only while idle.
module cad_divider #(
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Request
    input wire logic start_i,
    input wire logic [2*DW-1:0] dividend_i,
    input wire logic [DW-1:0] divisor_i,
    // Answer
    output logic done_o,
    output logic [2*DW-1:0] quot_o,
    output logic [DW-1:0] rem_o
);

    // Width must be whole bytes
    if (DW < 8 || DW % 8 != 0) begin : g_bad_width
        $error("cad_divider: DW must be a multiple of 8");
    end

    logic [DW-1:0] dvs; // Held divisor
    logic [$clog2(2*DW+1)-1:0] cnt; // Steps left
    logic busy; // Iterating
    logic [DW+1:0] trial; // Shifted remainder minus divisor

    // Trial subtraction of one step
    always_comb begin
        trial = {1'b0, rem_o, quot_o[2*DW-1]} - {2'b00, dvs};
    end

    // Iteration: shift in quotient bit, keep difference as remainder if no borrow
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            done_o <= 1'b0;
            cnt <= '0;
            dvs <= '0;
            quot_o <= '0;
            rem_o <= '0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                quot_o <= dividend_i;
                rem_o <= '0;
                dvs <= divisor_i;
                cnt <= ($clog2(2*DW+1))'(2*DW);
                busy <= 1'b1;
            end else if (busy) begin
                // No borrow: subtract and set quotient bit
                if (!trial[DW+1]) begin
                    rem_o <= trial[DW-1:0];
                    quot_o <= {quot_o[2*DW-2:0], 1'b1};
                end else begin
                    rem_o <= {rem_o[DW-2:0], quot_o[2*DW-1]};
                    quot_o <= {quot_o[2*DW-2:0], 1'b0};
                end
                cnt <= cnt - 1'b1;
                // Last step
                if (cnt == 1) begin
                    busy <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

endmodule : cad_divider

// ===== cad_datapath.sv
// Datapath: divide, compare, logic, shift, rotate, bit ops on 8 x 32 regs.
// Assumes a decoder gives one request at a time while ready is high.
// Summary of operation
// - Unsigned 16/8 and 32/16 divide
// - Signed divide, same two forms
// - Compare sets flags, register unchanged
// - Negate: zero minus operand
// - Sign extend byte to word, word to long
// - Zero extend byte to word, word to long
// - AND with register or immediate
// - OR with register or immediate
// - XOR with register or immediate
// - Complement inverts every operand bit
// - Arithmetic shifts, right keeps sign
// - Logical shifts insert zero
// - Rotates wrap shifted-out bit around
// - Rotates through carry flag
// - Set selected byte bit
// - Clear selected byte bit
// - Invert selected byte bit
// - Zero flag gets inverse of bit
// - Carry ANDed with selected bit
// - Carry AND inverse bit, immediate only
// - Eight 32-bit registers, word and byte views
module cad_datapath
    import cad_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Instruction request
    input wire logic req_valid_i,
    input wire cad_req_t req_i,
    input wire logic [7:0] mem_rdata_i,
    // Register observation
    input wire logic [2:0] peek_sel_i,
    // Status and results
    output logic ready_o,
    output logic done_o,
    output logic [7:0] cond_code_o,
    output cad_mem_t mem_o,
    output logic [31:0] peek_data_o
);

    // Field of a register at a size; idx[3] picks low byte / upper word
    function automatic logic [31:0] get_fld(logic [31:0] r, cad_size_t s, logic [3:0] idx);
        unique case (s)
            SZ_B: get_fld = {24'h00_0000, idx[3] ? r[7:0] : r[15:8]};
            SZ_W: get_fld = {16'h0000, idx[3] ? r[31:16] : r[15:0]};
            default: get_fld = r;
        endcase
    endfunction : get_fld

    // Merge a field back, leaving other bits untouched
    function automatic logic [31:0] put_fld(logic [31:0] r, cad_size_t s, logic [3:0] idx, logic [31:0] v);
        put_fld = r;
        unique case (s)
            SZ_B: if (idx[3]) put_fld[7:0] = v[7:0]; else put_fld[15:8] = v[7:0];
            SZ_W: if (idx[3]) put_fld[31:16] = v[15:0]; else put_fld[15:0] = v[15:0];
            default: put_fld = v;
        endcase
    endfunction : put_fld

    // Mask of a size
    function automatic logic [31:0] msk(cad_size_t s);
        unique case (s)
            SZ_B: msk = 32'h0000_00FF;
            SZ_W: msk = 32'h0000_FFFF;
            default: msk = 32'hFFFF_FFFF;
        endcase
    endfunction : msk

    // Top bit position of a size
    function automatic logic [4:0] top(cad_size_t s);
        unique case (s)
            SZ_B: top = 5'd7;
            SZ_W: top = 5'd15;
            default: top = 5'd31;
        endcase
    endfunction : top

    logic [31:0] gpr [NUM_GPR]; // General registers
    cad_state_t state; // Controller state
    cad_state_t next_state;
    cad_req_t cur; // Held request
    logic [7:0] mem_byte; // Held memory operand
    logic [7:0] cc; // Condition codes
    logic [7:0] next_cc;
    logic wr_en; // Register write-back
    logic [31:0] wr_val;
    logic mem_we; // Memory write-back
    logic [7:0] mem_wd;
    logic fin; // Instruction completes
    logic div_start; // Divider launch
    logic [31:0] div_dvd; // Dividend magnitude
    logic [15:0] div_dvs; // Divisor magnitude
    logic dvd_neg, dvs_neg; // Operand signs of held divide
    logic next_dvd_neg, next_dvs_neg;
    logic div_done;
    logic [31:0] div_q;
    logic [15:0] div_r;

    // Multi-cycle divide engine
    cad_divider #(.DW(DIV_W)) u_div (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(div_start),
        .dividend_i(div_dvd),
        .divisor_i(div_dvs),
        .done_o(div_done),
        .quot_o(div_q),
        .rem_o(div_r)
    );

    // Operation core
    always_comb begin
        logic [31:0] rreg, a, b, m, res, sb, q, rm, srcb, dfld;
        logic [4:0] t;
        logic [2:0] bn;
        logic bit_v, out_b, fill, is_div, sgn, bsz;
        rreg = gpr[cur.dst[2:0]];
        bsz = (cur.size == SZ_B);
        srcb = get_fld(gpr[cur.src[2:0]], SZ_B, cur.src);
        dfld = get_fld(gpr[cur.src[2:0]], bsz ? SZ_B : SZ_W, cur.src); // Divisor field
        m = msk(cur.size);
        t = top(cur.size);
        a = get_fld(rreg, cur.size, cur.dst);
        b = cur.use_imm ? (cur.imm & m) : get_fld(gpr[cur.src[2:0]], cur.size, cur.src);
        res = a;
        next_cc = cc;
        next_state = state;
        wr_en = 1'b0;
        wr_val = rreg;
        mem_we = 1'b0;
        mem_wd = mem_byte;
        fin = 1'b0;
        div_start = 1'b0;
        div_dvd = '0;
        div_dvs = '0;
        next_dvd_neg = dvd_neg;
        next_dvs_neg = dvs_neg;
        out_b = 1'b0;
        fill = 1'b0;
        q = '0;
        rm = '0;
        is_div = (cur.op == OP_DIVU) || (cur.op == OP_DIVS);
        sgn = (cur.op == OP_DIVS);
        // Byte operand and bit number for bit operations
        sb = cur.use_mem ? {24'h00_0000, mem_byte} : get_fld(rreg, SZ_B, cur.dst);
        bn = (cur.use_imm || cur.op == OP_CARRY_AND_INVERTED_BIT) ? cur.imm[2:0] : srcb[2:0];
        bit_v = sb[bn];
        unique case (state)
            // Waiting for a request
            ST_IDLE: begin
                if (req_valid_i) next_state = ST_EXEC;
            end
            // One-cycle operations, or divide launch
            ST_EXEC: begin
                if (is_div) begin
                    // Byte form: word / byte; word form: long / word
                    div_dvd = bsz ? get_fld(rreg, SZ_W, cur.dst) : rreg;
                    div_dvs = dfld[15:0];
                    next_dvd_neg = sgn & (bsz ? div_dvd[15] : div_dvd[31]);
                    next_dvs_neg = sgn & (bsz ? div_dvs[7] : div_dvs[15]);
                    if (next_dvd_neg) div_dvd = (bsz ? 32'h0000_FFFF : 32'hFFFF_FFFF) & (~div_dvd + 32'h0000_0001);
                    if (next_dvs_neg) div_dvs = (bsz ? 16'h00FF : 16'hFFFF) & (~div_dvs + 16'h0001);
                    div_start = 1'b1;
                    next_state = ST_DIV;
                end else begin
                    fin = 1'b1;
                    next_state = ST_IDLE;
                    unique case (cur.op)
                        OP_CMP, OP_NEG: begin
                            // Compare: a - b; negate: 0 - a
                            logic [31:0] x, y;
                            x = (cur.op == OP_CMP) ? a : 32'h0000_0000;
                            y = (cur.op == OP_CMP) ? b : a;
                            res = (x - y) & m;
                            next_cc[FLAG_C] = x < y;
                            next_cc[FLAG_V] = (x[t] != y[t]) && (res[t] != x[t]);
                            wr_en = (cur.op == OP_NEG);
                        end
                        OP_EXTS, OP_EXTU, OP_AND, OP_OR, OP_XOR, OP_NOT: begin
                            // Logic on sized views; extension widens the low half
                            if (cur.op == OP_AND) res = a & b;
                            else if (cur.op == OP_OR) res = a | b;
                            else if (cur.op == OP_XOR) res = a ^ b;
                            else if (cur.op == OP_NOT) res = ~a & m;
                            else if (cur.size == SZ_L)
                                res = {(cur.op == OP_EXTS && a[15]) ? 16'hFFFF : 16'h0000, a[15:0]};
                            else
                                res = {16'h0000, (cur.op == OP_EXTS && a[7]) ? 8'hFF : 8'h00, a[7:0]};
                            next_cc[FLAG_V] = 1'b0;
                            wr_en = 1'b1;
                        end
                        OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT, OP_ROTATE_LEFT, OP_ROTATE_LEFT_VIA_CARRY: begin
                            // Bit entering at position 0
                            out_b = a[t];
                            if (cur.op == OP_ROTATE_LEFT) fill = a[t];
                            else if (cur.op == OP_ROTATE_LEFT_VIA_CARRY) fill = cc[FLAG_C];
                            res = ((a << 1) | {31'h0000_0000, fill}) & m;
                            next_cc[FLAG_C] = out_b;
                            next_cc[FLAG_V] = (cur.op == OP_ARITH_SHIFT_LEFT) && (res[t] != a[t]);
                            wr_en = 1'b1;
                        end
                        OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_VIA_CARRY: begin
                            // Bit entering at the top of the size
                            out_b = a[0];
                            if (cur.op == OP_ARITH_SHIFT_RIGHT) fill = a[t];
                            else if (cur.op == OP_ROTATE_RIGHT) fill = a[0];
                            else if (cur.op == OP_ROTATE_RIGHT_VIA_CARRY) fill = cc[FLAG_C];
                            res = (a >> 1) | ({31'h0000_0000, fill} << t);
                            next_cc[FLAG_C] = out_b;
                            next_cc[FLAG_V] = 1'b0;
                            wr_en = 1'b1;
                        end
                        OP_SINGLE_BIT_SET, OP_SINGLE_BIT_CLEAR, OP_SINGLE_BIT_INVERT: begin
                            res = sb;
                            if (cur.op == OP_SINGLE_BIT_SET) res[bn] = 1'b1;
                            else if (cur.op == OP_SINGLE_BIT_CLEAR) res[bn] = 1'b0;
                            else res[bn] = ~bit_v;
                            mem_we = cur.use_mem;
                            mem_wd = res[7:0];
                            wr_en = ~cur.use_mem;
                        end
                        OP_SINGLE_BIT_TEST: next_cc[FLAG_Z] = ~bit_v;
                        OP_CARRY_AND_BIT: next_cc[FLAG_C] = cc[FLAG_C] & bit_v;
                        OP_CARRY_AND_INVERTED_BIT: next_cc[FLAG_C] = cc[FLAG_C] & ~bit_v;
                        default: ;
                    endcase
                    // N and Z from the sized result of value operations
                    if (cur.op < OP_SINGLE_BIT_SET) begin
                        next_cc[FLAG_N] = res[t];
                        next_cc[FLAG_Z] = (res & m) == 32'h0000_0000;
                    end
                    // Bit operations write the byte view
                    wr_val = (cur.op inside {OP_SINGLE_BIT_SET, OP_SINGLE_BIT_CLEAR, OP_SINGLE_BIT_INVERT})
                           ? put_fld(rreg, SZ_B, cur.dst, res) : put_fld(rreg, cur.size, cur.dst, res);
                end
            end
            // Divide running; fix signs and pack remainder:quotient
            ST_DIV: begin
                if (div_done) begin
                    q = (dvd_neg ^ dvs_neg) ? (~div_q + 32'h0000_0001) : div_q;
                    rm = dvd_neg ? (~{16'h0000, div_r} + 32'h0000_0001) : {16'h0000, div_r};
                    if (bsz)
                        wr_val = put_fld(rreg, SZ_W, cur.dst, {16'h0000, rm[7:0], q[7:0]});
                    else
                        wr_val = {rm[15:0], q[15:0]};
                    // Flags follow the divisor
                    next_cc[FLAG_N] = dvs_neg;
                    next_cc[FLAG_Z] = (dfld == 32'h0000_0000);
                    wr_en = 1'b1;
                    fin = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Controller state and request capture
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cur <= '0;
            mem_byte <= 8'h00;
            dvd_neg <= 1'b0;
            dvs_neg <= 1'b0;
        end else begin
            state <= next_state;
            dvd_neg <= next_dvd_neg;
            dvs_neg <= next_dvs_neg;
            if (state == ST_IDLE && req_valid_i) begin
                cur <= req_i;
                mem_byte <= mem_rdata_i;
            end
        end
    end

    // Register file write-back
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_GPR; i++) gpr[i] <= GPR_RESET;
        end else if (wr_en) begin
            gpr[cur.dst[2:0]] <= wr_val;
        end
    end

    // Condition codes
    always_ff @(posedge mclk_i) begin
        if (rst_i) cc <= CC_RESET;
        else cc <= next_cc;
    end

    // Registered outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ready_o <= 1'b1;
            done_o <= 1'b0;
            cond_code_o <= CC_RESET;
            mem_o <= '0;
            peek_data_o <= GPR_RESET;
        end else begin
            ready_o <= (next_state == ST_IDLE);
            done_o <= fin;
            cond_code_o <= next_cc;
            mem_o.we <= mem_we;
            mem_o.data <= mem_wd;
            peek_data_o <= (wr_en && cur.dst[2:0] == peek_sel_i) ? wr_val : gpr[peek_sel_i];
        end
    end

endmodule : cad_datapath

// ===== cad_datapath_checker.sv
// Checker of datapath ports: memory bit ops, flags, latency.
// Assumes it is bound to cad_datapath.
module cad_datapath_checker
    import cad_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Request side
    input wire logic req_valid_i,
    input wire cad_req_t req_i,
    input wire logic [7:0] mem_rdata_i,
    // Result side
    input wire logic ready_o,
    input wire logic done_o,
    input wire logic [7:0] cond_code_o,
    input wire cad_mem_t mem_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    cad_req_t cap; // Request held from its take
    logic [7:0] cap_mem; // Memory byte held from the take
    logic cap_c; // Carry before the operation
    logic [2:0] bn; // Bit number from the immediate
    logic take; // Request accepted this edge
    logic mi; // Memory operand, immediate bit number
    assign take = req_valid_i && ready_o;
    assign mi = cap.use_mem && cap.use_imm;
    assign bn = cap.imm[2:0];

    // Capture what the operation started from
    always_ff @(posedge mclk_i) begin
        if (take) begin
            cap <= req_i;
            cap_mem <= mem_rdata_i;
            cap_c <= cond_code_o[FLAG_C];
        end
    end

    a_mem_bit_set: assert property (done_o && cap.op == OP_SINGLE_BIT_SET && mi
        |-> mem_o.we && mem_o.data == (cap_mem | (8'h01 << bn))) else $error("bit set write-back wrong");
    a_mem_bit_clear: assert property (done_o && cap.op == OP_SINGLE_BIT_CLEAR && mi
        |-> mem_o.we && mem_o.data == (cap_mem & ~(8'h01 << bn))) else $error("bit clear write-back wrong");
    a_mem_bit_invert: assert property (done_o && cap.op == OP_SINGLE_BIT_INVERT && mi
        |-> mem_o.we && mem_o.data == (cap_mem ^ (8'h01 << bn))) else $error("bit invert write-back wrong");
    a_test_zero_flag: assert property (done_o && cap.op == OP_SINGLE_BIT_TEST && mi
        |-> cond_code_o[FLAG_Z] == !cap_mem[bn] && !mem_o.we) else $error("bit test zero flag wrong");
    a_carry_and_bit: assert property (done_o && cap.op == OP_CARRY_AND_BIT && mi
        |-> cond_code_o[FLAG_C] == (cap_c & cap_mem[bn])) else $error("carry and bit wrong");
    a_carry_and_inv: assert property (done_o && cap.op == OP_CARRY_AND_INVERTED_BIT && cap.use_mem
        |-> cond_code_o[FLAG_C] == (cap_c & !cap_mem[bn])) else $error("carry and inverted bit wrong");
    a_logic_v_clear: assert property (done_o && cap.op inside {OP_AND, OP_OR, OP_XOR, OP_NOT}
        |-> !cond_code_o[FLAG_V]) else $error("logic op left overflow set");
    a_div_latency: assert property (take && req_i.op inside {OP_DIVU, OP_DIVS}
        |=> (!done_o && !ready_o) [*8] ##[20:40] done_o) else $error("divide latency wrong");
    a_single_latency: assert property (take && !(req_i.op inside {OP_DIVU, OP_DIVS})
        |=> !ready_o ##[1:2] done_o) else $error("single-cycle op latency wrong");
endmodule : cad_datapath_checker

// ===== cad_datapath_tb.sv
// Self-checking bench: registers built by immediate OR, read via peek.
// Assumes cad_pkg and cad_datapath compile first.
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module cad_datapath_tb
    import cad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0; // Clock, 25 MHz
    logic rst_i = 1; // Synchronous reset
    logic req_valid_i = 0; // Request strobe
    cad_req_t req_i = '0; // Request
    logic [7:0] mem_rdata_i = 8'h00; // Memory byte operand
    logic [2:0] peek_sel_i = 3'h0; // Observed register
    logic ready_o, done_o; // Status
    logic [7:0] cond_code_o; // Flags
    cad_mem_t mem_o; // Memory write-back
    logic [31:0] peek_data_o; // Observed register value
    int fails = 0; // Mismatch count
    int total_checks = 0; // Comparison count
    logic [7:0] cc; // Flags seen at completion
    cad_mem_t mw; // Write-back seen at completion
    logic [31:0] pk; // Peeked value

    // Clock generator
    always #20 mclk_i = ~mclk_i;

    cad_datapath dut (.*);

    // Print counts and verdict, then stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // Issue one request and wait for its completion pulse
    task automatic run(input cad_op_t o, input cad_size_t s, input logic [3:0] d, input logic [3:0] sr,
        input logic ui, input logic um, input logic [31:0] im, input logic [7:0] md);
        int n = 0;
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_i <= '{op: o, size: s, dst: d, src: sr, use_imm: ui, use_mem: um, imm: im};
        mem_rdata_i <= md;
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (done_o !== 1'b1 && n < 60);
        `CHK("completion", 1'b1, done_o)
        cc = cond_code_o;
        mw = mem_o;
    endtask : run

    // Read one register through the peek port
    task automatic peek(input logic [2:0] r);
        @(posedge mclk_i);
        peek_sel_i <= r;
        @(posedge mclk_i);
        @(negedge mclk_i);
        pk = peek_data_o;
    endtask : peek

    // Register operation followed by a readback of its destination
    task automatic rchk(input cad_op_t o, input cad_size_t s, input logic [3:0] d, input logic [3:0] sr,
        input logic ui, input logic [31:0] im, input logic [31:0] ex, input string nm);
        run(o, s, d, sr, ui, 1'b0, im, 8'h00);
        peek(d[2:0]);
        `CHK(nm, ex, pk)
    endtask : rchk

    // Values after reset
    task automatic t_reset();
        `CHK("ready", 1'b1, ready_o)
        `CHK("flags", 8'h00, cond_code_o)
        for (int r = 0; r < NUM_GPR; r++) begin
            peek(r[2:0]);
            `CHK("reg reset", 32'h0000_0000, pk)
        end
        $display("test reset done");
    endtask : t_reset

    // Logic, compare and negate on sub-register views of ER1
    task automatic t_logic();
        rchk(OP_OR, SZ_L, 4'h1, 4'h0, 1, 32'h8421_F00F, 32'h8421_F00F, "or");
        rchk(OP_AND, SZ_W, 4'h9, 4'h0, 1, 32'h0000_0FF0, 32'h0420_F00F, "and");
        rchk(OP_XOR, SZ_B, 4'h9, 4'h0, 1, 32'h0000_00FF, 32'h0420_F0F0, "xor");
        `CHK("xor neg", 1'b1, cc[FLAG_N])
        rchk(OP_NOT, SZ_B, 4'h1, 4'h0, 1, 32'h0000_0000, 32'h0420_0FF0, "not");
        rchk(OP_CMP, SZ_L, 4'h1, 4'h0, 1, 32'h0420_0FF0, 32'h0420_0FF0, "cmp keep");
        `CHK("cmp zero", 2'b10, {cc[FLAG_Z], cc[FLAG_C]})
        rchk(OP_CMP, SZ_B, 4'h9, 4'h0, 1, 32'h0000_00F1, 32'h0420_0FF0, "cmp b keep");
        `CHK("cmp borrow", 2'b11, {cc[FLAG_N], cc[FLAG_C]})
        rchk(OP_NEG, SZ_W, 4'h1, 4'h0, 1, 32'h0000_0000, 32'h0420_F010, "neg");
        $display("test logic done");
    endtask : t_logic

    // Sign and zero extension on ER2
    task automatic t_ext();
        rchk(OP_OR, SZ_L, 4'h2, 4'h0, 1, 32'h1234_5680, 32'h1234_5680, "ext load");
        rchk(OP_EXTS, SZ_W, 4'h2, 4'h0, 0, 32'h0, 32'h1234_FF80, "exts w");
        rchk(OP_EXTU, SZ_L, 4'h2, 4'h0, 0, 32'h0, 32'h0000_FF80, "extu l");
        rchk(OP_EXTS, SZ_L, 4'h2, 4'h0, 0, 32'h0, 32'hFFFF_FF80, "exts l");
        rchk(OP_EXTU, SZ_W, 4'h2, 4'h0, 0, 32'h0, 32'hFFFF_0080, "extu w");
        $display("test extend done");
    endtask : t_ext

    // Shift and rotate chain on the low byte of ER3
    task automatic t_shift();
        cad_op_t so[8] = '{OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_VIA_CARRY, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT,
            OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ARITH_SHIFT_LEFT};
        logic [7:0] sv[8] = '{8'hC0, 8'hE0, 8'hF0, 8'hE0, 8'hC1, 8'h83, 8'h41, 8'h82};
        logic sc[8] = '{1, 0, 0, 1, 1, 1, 1, 0};
        rchk(OP_OR, SZ_L, 4'h3, 4'h0, 1, 32'hA5A5_A581, 32'hA5A5_A581, "shift load");
        for (int i = 0; i < 8; i++) begin
            rchk(so[i], SZ_B, 4'hB, 4'h0, 0, 32'h0, {24'hA5_A5A5, sv[i]}, "shift value");
            `CHK("shift carry", sc[i], cc[FLAG_C])
        end
        $display("test shift done");
    endtask : t_shift

    // Single-bit operations on the low byte of ER4
    task automatic t_bits();
        rchk(OP_SINGLE_BIT_SET, SZ_B, 4'hC, 4'h0, 1, 32'h7, 32'h0000_0080, "set imm");
        rchk(OP_SINGLE_BIT_SET, SZ_B, 4'hC, 4'h9, 0, 32'h7, 32'h0000_0081, "set reg");
        rchk(OP_SINGLE_BIT_CLEAR, SZ_B, 4'hC, 4'h0, 1, 32'h7, 32'h0000_0001, "clear");
        rchk(OP_SINGLE_BIT_INVERT, SZ_B, 4'hC, 4'h0, 1, 32'h3, 32'h0000_0009, "invert");
        rchk(OP_SINGLE_BIT_TEST, SZ_B, 4'hC, 4'h0, 1, 32'h3, 32'h0000_0009, "test keep");
        `CHK("test set bit", 1'b0, cc[FLAG_Z])
        rchk(OP_SINGLE_BIT_TEST, SZ_B, 4'hC, 4'h0, 1, 32'h2, 32'h0000_0009, "test keep");
        `CHK("test clear bit", 1'b1, cc[FLAG_Z])
        rchk(OP_CMP, SZ_B, 4'hC, 4'h0, 1, 32'h0000_000A, 32'h0000_0009, "cmp");
        rchk(OP_CARRY_AND_BIT, SZ_B, 4'hC, 4'h0, 1, 32'h0, 32'h0000_0009, "cand");
        `CHK("carry and", 1'b1, cc[FLAG_C])
        rchk(OP_CARRY_AND_INVERTED_BIT, SZ_B, 4'hC, 4'h0, 1, 32'h0, 32'h0000_0009, "candi");
        `CHK("carry and inv", 1'b0, cc[FLAG_C])
        $display("test bits done");
    endtask : t_bits

    // Single-bit operations on a memory byte
    task automatic t_mem();
        run(OP_SINGLE_BIT_SET, SZ_B, 4'hC, 4'h0, 1, 1, 32'h0, 8'h5A);
        `CHK("mem set", 9'h15B, {mw.we, mw.data})
        run(OP_SINGLE_BIT_CLEAR, SZ_B, 4'hC, 4'h0, 1, 1, 32'h1, 8'h5A);
        `CHK("mem clear", 9'h158, {mw.we, mw.data})
        run(OP_SINGLE_BIT_INVERT, SZ_B, 4'hC, 4'h0, 1, 1, 32'h7, 8'h5A);
        `CHK("mem invert", 9'h1DA, {mw.we, mw.data})
        run(OP_SINGLE_BIT_TEST, SZ_B, 4'hC, 4'h0, 1, 1, 32'h0, 8'h5A);
        `CHK("mem test", 2'b01, {mw.we, cc[FLAG_Z]})
        run(OP_CMP, SZ_B, 4'hC, 4'h0, 1, 0, 32'h0000_000A, 8'h00);
        run(OP_CARRY_AND_BIT, SZ_B, 4'hC, 4'h0, 1, 1, 32'h1, 8'h5A);
        `CHK("mem carry and", 1'b1, cc[FLAG_C])
        run(OP_CARRY_AND_INVERTED_BIT, SZ_B, 4'hC, 4'h9, 0, 1, 32'h1, 8'h5A);
        `CHK("mem carry and inv", 1'b0, cc[FLAG_C])
        peek(3'h4);
        `CHK("reg untouched", 32'h0000_0009, pk)
        $display("test memory bits done");
    endtask : t_mem

    // Unsigned and signed divide, both size forms
    task automatic t_div();
        rchk(OP_OR, SZ_W, 4'h5, 4'h0, 1, 32'h0000_0064, 32'h0000_0064, "div load");
        rchk(OP_OR, SZ_B, 4'hE, 4'h0, 1, 32'h0000_0007, 32'h0000_0007, "divisor load");
        rchk(OP_DIVU, SZ_B, 4'h5, 4'hE, 0, 32'h0, 32'h0000_020E, "divu b");
        rchk(OP_DIVU, SZ_W, 4'h5, 4'h6, 0, 32'h0, 32'h0001_004B, "divu w");
        rchk(OP_OR, SZ_L, 4'h7, 4'h0, 1, 32'hFFFF_FF9C, 32'hFFFF_FF9C, "sdiv load");
        rchk(OP_DIVS, SZ_W, 4'h7, 4'h6, 0, 32'h0, 32'hFFFE_FFF2, "divs w");
        rchk(OP_DIVS, SZ_B, 4'h7, 4'hE, 0, 32'h0, 32'hFFFE_00FE, "divs b");
        $display("test divide done");
    endtask : t_div

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset();
        t_logic();
        t_ext();
        t_shift();
        t_bits();
        t_mem();
        t_div();
        end_sim();
    end

    // Watchdog for a hung handshake
    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        end_sim();
    end
endmodule : cad_datapath_tb

bind cad_datapath cad_datapath_checker chk (.*);
